// [src/fag_host.sv]
/*
 * Host controller for a parallel NOR flash: identification-query entry and
 * exit, single bus reads and writes, guard-bit status polling and password
 * unlock with enforced spacing. Software drives it through a plain register port.
 * Assumes the flash data input is synchronous to clk and the pin wire is
 * resolved outside from the output enable.
 */
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module fag_host import fag_pkg::*; #(
    parameter int ADDR_W = 26,
    parameter logic [15:0] PW_CMD_DATA = 16'h0000,
    parameter logic [15:0] PW_ADDR = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic flash_ce_b,
    output logic flash_oe_b,
    output logic flash_we_b,
    output logic flash_reset_b
);

    typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WPULSE, S_RWAIT, S_RECOV, S_PWWAIT, S_HWRST} fag_state_t;

    typedef struct packed {
        fag_state_t state;
        logic [2:0] op;
        logic [2:0] step;
        logic [9:0] cnt;
        logic [9:0] gap;
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic [63:0] pw;
        logic [15:0] rdata;
        logic [15:0] prev;
        logic busy;
        logic id_mode;
        logic refused;
        logic poll_ok;
        logic poll_erase;
        logic poll_fail;
        logic [31:0] rd;
        logic [ADDR_W-1:0] f_addr;
        logic [15:0] f_dq;
        logic f_oe;
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic frst_b;
    } fag_regs_t;

    typedef struct packed {
        logic wr;
        logic last;
        logic [ADDR_W-1:0] a;
        logic [15:0] d;
    } fag_cycle_t;

    fag_regs_t st_reg;
    fag_regs_t st_next;

    // Selects the bus cycle for a given operation and step.
    function automatic fag_cycle_t cycle_of(input logic [2:0] op, input logic [2:0] step,
                                            input logic [ADDR_W-1:0] addr, input logic [15:0] wdata,
                                            input logic [63:0] pw);
        fag_cycle_t c;
        c = '{wr: 1'b1, last: 1'b0, a: ADDR_W'(UNLOCK1_ADDR), d: UNLOCK1_DATA};
        case (op)
            OP_ID_ENTER, OP_PW_UNLOCK: begin
                if (step == 3'd1) begin
                    c.a = ADDR_W'(UNLOCK2_ADDR);
                    c.d = UNLOCK2_DATA;
                end else if (step == 3'd2) begin
                    c.d = (op == OP_ID_ENTER) ? ID_ENTER_DATA : PW_CMD_DATA;
                    c.last = (op == OP_ID_ENTER);
                end else if (step >= 3'd3) begin
                    c.a = ADDR_W'(PW_ADDR);
                    c.d = pw[16 * (step - 3'd3) +: 16];
                    c.last = (step == 3'd6);
                end
            end
            OP_RESET: begin
                c.a = addr;
                c.d = RESET_DATA;
                c.last = 1'b1;
            end
            OP_WRITE: begin
                c.a = addr;
                c.d = wdata;
                c.last = 1'b1;
            end
            default: begin
                c.wr = 1'b0;
                c.a = addr;
                c.last = 1'b1;
            end
        endcase
        return c;
    endfunction

    fag_cycle_t cur;
    assign cur = cycle_of(st_reg.op, st_reg.step, st_reg.addr, st_reg.wdata, st_reg.pw);

    // Next-state logic for the register port, the sequencer and the pins.
    always_comb begin
        logic [2:0] op_in;
        logic refuse;
        op_in = reg_wdata[2:0];
        refuse = 1'b0;
        st_next = st_reg;
        st_next.rd = 32'h0000_0000;
        if (st_reg.gap != 10'h000) begin
            st_next.gap = st_reg.gap - 10'h001;
        end
        // Register writes; data registers stay writable while busy.
        if (reg_wr) begin
            case (reg_addr)
                REG_ADDR: st_next.addr = reg_wdata[ADDR_W-1:0];
                REG_WDATA: st_next.wdata = reg_wdata[15:0];
                REG_PW0: st_next.pw[15:0] = reg_wdata[15:0];
                REG_PW1: st_next.pw[31:16] = reg_wdata[15:0];
                REG_PW2: st_next.pw[47:32] = reg_wdata[15:0];
                REG_PW3: st_next.pw[63:48] = reg_wdata[15:0];
                default: ;
            endcase
        end
        // Register reads answer in the following cycle only.
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: st_next.rd = {29'h0000_0000, st_reg.op};
                REG_ADDR: st_next.rd = 32'(st_reg.addr);
                REG_WDATA: st_next.rd = {16'h0000, st_reg.wdata};
                REG_STATUS: st_next.rd = {26'h000_0000, st_reg.poll_fail, st_reg.poll_erase,
                                          st_reg.poll_ok, st_reg.refused, st_reg.id_mode, st_reg.busy};
                REG_RDATA: st_next.rd = {16'h0000, st_reg.rdata};
                default: st_next.rd = 32'h0000_0000;
            endcase
        end
        case (st_reg.state)
            S_IDLE: begin
                if (reg_wr && reg_addr == REG_CTRL && op_in != 3'h0) begin
                    // In query mode only reset, hardware reset and plain reads go out.
                    if (st_reg.id_mode && !(op_in == OP_RESET || op_in == OP_READ || op_in == OP_HW_RESET)) begin
                        refuse = 1'b1;
                    end
                    if (op_in == OP_PW_UNLOCK && st_reg.gap != 10'h000) begin
                        refuse = 1'b1;
                    end
                    st_next.refused = refuse;
                    if (!refuse) begin
                        st_next.op = op_in;
                        st_next.step = 3'd0;
                        st_next.busy = 1'b1;
                        if (op_in == OP_POLL) begin
                            st_next.poll_ok = 1'b0;
                            st_next.poll_erase = 1'b0;
                            st_next.poll_fail = 1'b0;
                        end
                        if (op_in == OP_HW_RESET) begin
                            st_next.frst_b = 1'b0;
                            st_next.cnt = HWRST_CYC;
                            st_next.state = S_HWRST;
                        end else begin
                            st_next.state = S_ISSUE;
                        end
                    end
                end
            end
            S_ISSUE: begin
                // Address, data and strobes go out together; no setup needed.
                st_next.f_addr = cur.a;
                st_next.ce_b = 1'b0;
                if (cur.wr) begin
                    st_next.f_dq = cur.d;
                    st_next.f_oe = 1'b1;
                    st_next.we_b = 1'b0;
                    st_next.cnt = WP_CYC;
                    st_next.state = S_WPULSE;
                end else begin
                    st_next.oe_b = 1'b0;
                    st_next.cnt = ACC_CYC;
                    st_next.state = S_RWAIT;
                end
            end
            S_WPULSE: begin
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.we_b = 1'b1;
                    st_next.ce_b = 1'b1;
                    st_next.cnt = REC_CYC;
                    st_next.state = S_RECOV;
                end
            end
            S_RWAIT: begin
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.rdata = flash_dq_in;
                    st_next.oe_b = 1'b1;
                    st_next.ce_b = 1'b1;
                    st_next.cnt = REC_CYC;
                    st_next.state = S_RECOV;
                end
            end
            S_RECOV: begin
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.f_oe = 1'b0;
                    st_next.state = S_IDLE;
                    if (st_reg.op == OP_POLL) begin
                        // Read until the toggle flag stands, then judge the value.
                        if (st_reg.step == 3'd0 || st_reg.rdata[TOGGLE_BIT] != st_reg.prev[TOGGLE_BIT]) begin
                            st_next.prev = st_reg.rdata;
                            st_next.step = 3'd1;
                            st_next.state = S_ISSUE;
                        end else begin
                            st_next.poll_ok = (st_reg.rdata == POLL_PROG_OK) || (st_reg.rdata == POLL_ERASE_OK);
                            st_next.poll_erase = (st_reg.rdata == POLL_ERASE_OK);
                            st_next.poll_fail = (st_reg.rdata != POLL_PROG_OK) && (st_reg.rdata != POLL_ERASE_OK);
                            st_next.busy = 1'b0;
                        end
                    end else if (!cur.last) begin
                        st_next.step = st_reg.step + 3'd1;
                        st_next.state = S_ISSUE;
                    end else if (st_reg.op == OP_PW_UNLOCK) begin
                        st_next.cnt = PW_CYC;
                        st_next.gap = PW_CYC;
                        st_next.state = S_PWWAIT;
                    end else begin
                        st_next.busy = 1'b0;
                        if (st_reg.op == OP_ID_ENTER) begin
                            st_next.id_mode = 1'b1;
                        end
                        if (st_reg.op == OP_RESET) begin
                            st_next.id_mode = 1'b0;
                        end
                    end
                end
            end
            S_PWWAIT: begin
                // The unlock takes effect only after the wait has run out.
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.busy = 1'b0;
                    st_next.state = S_IDLE;
                end
            end
            S_HWRST: begin
                st_next.cnt = st_reg.cnt - 10'h001;
                if (st_reg.cnt == 10'h001) begin
                    st_next.frst_b = 1'b1;
                    st_next.id_mode = 1'b0;
                    st_next.busy = 1'b0;
                    st_next.state = S_IDLE;
                end
            end
            default: st_next.state = S_IDLE;
        endcase
    end

    // State register with synchronous active-low reset.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.state <= S_IDLE;
            st_reg.pw <= 64'hffff_ffff_ffff_ffff;
            st_reg.ce_b <= 1'b1;
            st_reg.oe_b <= 1'b1;
            st_reg.we_b <= 1'b1;
            st_reg.frst_b <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output is a field of the state register.
    assign reg_rdata = st_reg.rd;
    assign flash_addr = st_reg.f_addr;
    assign flash_dq_out = st_reg.f_dq;
    assign flash_dq_oe = st_reg.f_oe;
    assign flash_ce_b = st_reg.ce_b;
    assign flash_oe_b = st_reg.oe_b;
    assign flash_we_b = st_reg.we_b;
    assign flash_reset_b = st_reg.frst_b;

endmodule // fag_host

// [src/fag_pkg.sv]
/*
 * Shared constants of the flash mode and sector guard host controller:
 * register offsets, status bit positions, command bytes and bus timing.
 * Assumes a 200 MHz controller clock and a 16-bit wide flash data bus.
 */
package fag_pkg;

    // Controller clock period in picoseconds.
    localparam int CLK_PS = 5000;

    // Software register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam logic [7:0] REG_PW0 = 8'h14;
    localparam logic [7:0] REG_PW1 = 8'h18;
    localparam logic [7:0] REG_PW2 = 8'h1c;
    localparam logic [7:0] REG_PW3 = 8'h20;

    // Status register bit positions.
    localparam int ST_BUSY = 0;
    localparam int ST_ID_MODE = 1;
    localparam int ST_REFUSED = 2;
    localparam int ST_POLL_OK = 3;
    localparam int ST_POLL_ERASE = 4;
    localparam int ST_POLL_FAIL = 5;

    // Operation codes written to the control register.
    localparam logic [2:0] OP_ID_ENTER = 3'h1;
    localparam logic [2:0] OP_RESET = 3'h2;
    localparam logic [2:0] OP_READ = 3'h3;
    localparam logic [2:0] OP_WRITE = 3'h4;
    localparam logic [2:0] OP_PW_UNLOCK = 3'h5;
    localparam logic [2:0] OP_POLL = 3'h6;
    localparam logic [2:0] OP_HW_RESET = 3'h7;

    // Flash command bytes and unlock addresses in word mode.
    localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] ID_ENTER_DATA = 16'h0090;
    localparam logic [15:0] RESET_DATA = 16'h00f0;
    localparam logic [15:0] UNLOCK1_ADDR = 16'h0555;
    localparam logic [15:0] UNLOCK2_ADDR = 16'h02aa;

    // Guard-bit poll results that mean success.
    localparam logic [15:0] POLL_PROG_OK = 16'h0000;
    localparam logic [15:0] POLL_ERASE_OK = 16'h0001;
    localparam int TOGGLE_BIT = 6;

    // Bus timing in nanoseconds (password wait in microseconds), then in clock cycles (least times round up).
    localparam int T_WP_NS = 35;
    localparam int T_ACC_NS = 70;
    localparam int T_REC_NS = 20;
    localparam int T_HWRST_NS = 500;
    localparam int T_PW_US = 2;
    localparam logic [9:0] WP_CYC = 10'((T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [9:0] ACC_CYC = 10'((T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [9:0] REC_CYC = 10'((T_REC_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [9:0] HWRST_CYC = 10'((T_HWRST_NS * 1000 + CLK_PS - 1) / CLK_PS);
    localparam logic [9:0] PW_CYC = 10'((T_PW_US * 1000000 + CLK_PS - 1) / CLK_PS);

endpackage

// [testbench/fag_flash_model.sv]
/* Behavioural flash: unlock decoding, query mode, guard lock, password unlock.
   Assumes the host holds address and data past the rise of we_b. */
`timescale 1ns/1ps
module fag_flash_model import fag_pkg::*; #(
    parameter int ADDR_W = 26,
    parameter logic [15:0] PW_CMD_DATA = 16'h0000,
    parameter logic [15:0] PW_ADDR = 16'h0000,
    parameter logic [15:0] MAKER_ID = 16'h005a, // Arbitrary value.
    parameter logic PW_MODE = 1'b1
) (
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0] dq_out,
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic reset_b,
    output logic [15:0] dq_in,
    output logic id_mode,
    output logic persistent_guard_lock
);
    logic [15:0] protection_mode_lock = {13'h1fff, ~PW_MODE, PW_MODE, 1'b1};
    logic [63:0] password = 64'hffffffffffffffff;
    logic [63:0] pw_got = 64'h0;
    logic [1:0] seq = 2'h0;
    logic [2:0] pw_cnt = 3'h0;
    logic [2:0] tog = 3'h5;
    logic [15:0] word;
    logic [15:0] last = 16'h0;
    logic volatile_sector_guard_bit = 1'b1;
    // Power-up state of the mode and of the guard lock.
    initial begin
        id_mode = 1'b0;
        persistent_guard_lock = protection_mode_lock[2];
    end
    // Decodes each write word at the end of its pulse.
    always @(posedge we_b) begin
        if (id_mode) begin
            if (dq_out == RESET_DATA) id_mode <= 1'b0;
        end else if (pw_cnt != 3'h0) begin
            pw_got <= {dq_out, pw_got[63:16]};
            pw_cnt <= pw_cnt - 3'h1;
            if (pw_cnt == 3'h1 && {dq_out, pw_got[63:16]} == password)
                persistent_guard_lock <= #2000 1'b1;
        end else if (dq_out == RESET_DATA) begin
            seq <= 2'h0;
            if (!protection_mode_lock[2]) persistent_guard_lock <= 1'b0;
        end else if (seq == 2'h0 && addr[15:0] == UNLOCK1_ADDR && dq_out == UNLOCK1_DATA) seq <= 2'h1;
        else if (seq == 2'h1 && addr[15:0] == UNLOCK2_ADDR && dq_out == UNLOCK2_DATA) seq <= 2'h2;
        else begin
            seq <= 2'h0;
            if (seq == 2'h2 && addr[15:0] == UNLOCK1_ADDR && dq_out == ID_ENTER_DATA) id_mode <= 1'b1;
            if (seq == 2'h2 && addr[15:0] == UNLOCK1_ADDR && dq_out == PW_CMD_DATA) pw_cnt <= 3'h4;
        end
    end
    // Read word; address three toggles the poll bit a few times first.
    always_comb begin
        if (id_mode) word = addr[1:0] == 2'h0 ? MAKER_ID : {15'h0, ~volatile_sector_guard_bit};
        else if (addr[1:0] == 2'h3) word = {9'h0, tog[0], 6'h0};
        else word = {14'h0, addr[1:0]};
        dq_in = (!oe_b && !ce_b) ? word : ~last;
    end
    // Ends a read: remember the word and step the toggle count.
    always @(posedge oe_b) begin
        last <= word;
        if (!id_mode && addr[1:0] == 2'h3 && tog != 3'h0) tog <= tog - 3'h1;
    end
    // Hardware reset restores the volatile state.
    always @(negedge reset_b) begin
        id_mode <= 1'b0;
        seq <= 2'h0;
        pw_cnt <= 3'h0;
        volatile_sector_guard_bit <= 1'b1;
        persistent_guard_lock <= protection_mode_lock[2];
    end
endmodule // fag_flash_model

// [testbench/fag_host_properties.sv]
/* Checker of the flash pins and the register read port of the host.
   Assumes it is bound to every fag_host instance. */
`timescale 1ns/1ps
module fag_host_properties import fag_pkg::*; #(
    parameter int ADDR_W = 26,
    parameter logic [15:0] PW_CMD_DATA = 16'h0000,
    parameter logic [15:0] PW_ADDR = 16'h0000
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe,
    input wire logic flash_ce_b,
    input wire logic flash_oe_b,
    input wire logic flash_we_b,
    input wire logic flash_reset_b
);
    logic we_d_reg;
    logic [15:0] last_wr_reg;
    logic [9:0] gap_reg;
    logic we_start;
    logic pw_cmd;
    // A password command is the write that follows the second unlock word.
    assign we_start = we_d_reg && !flash_we_b;
    assign pw_cmd = we_start && last_wr_reg == UNLOCK2_DATA && flash_addr[15:0] == UNLOCK1_ADDR
        && flash_dq_out == PW_CMD_DATA;
    // Counts cycles since the last password command, saturating.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            we_d_reg <= 1'b1;
            last_wr_reg <= 16'h0;
            gap_reg <= 10'h3ff;
        end else begin
            we_d_reg <= flash_we_b;
            if (we_start) last_wr_reg <= flash_dq_out;
            if (pw_cmd) gap_reg <= 10'h0;
            else if (gap_reg != 10'h3ff) gap_reg <= gap_reg + 10'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_WE_LEN: assert property ($fell(flash_we_b) |-> !flash_we_b [*7] ##1 flash_we_b)
        else $error("write pulse length wrong");
    AST_WE_QUAL: assert property (!flash_we_b |-> !flash_ce_b && flash_dq_oe && flash_oe_b)
        else $error("write pulse without select or data");
    AST_DQ_HOLD: assert property ($rose(flash_we_b) |-> flash_dq_oe [*4] ##1 !flash_dq_oe)
        else $error("data hold after write wrong");
    AST_OE_LEN: assert property ($fell(flash_oe_b) |-> !flash_oe_b [*7] ##7 !flash_oe_b ##1 flash_oe_b)
        else $error("read strobe length wrong");
    AST_HW_RST: assert property ($fell(flash_reset_b) |-> ##99 !flash_reset_b ##1 flash_reset_b)
        else $error("hardware reset pulse length wrong");
    AST_RDATA: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    AST_PW_GAP: assert property (pw_cmd |-> gap_reg >= 10'h190)
        else $error("password commands too close");
    AST_IDLE: assert property (flash_ce_b |-> flash_we_b && flash_oe_b)
        else $error("strobe while deselected");
endmodule // fag_host_properties

bind fag_host fag_host_properties #(.ADDR_W(ADDR_W), .PW_CMD_DATA(PW_CMD_DATA), .PW_ADDR(PW_ADDR))
    u_fag_host_properties (.clk(clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_ce_b(flash_ce_b),
    .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_reset_b(flash_reset_b));

// [testbench/fag_host_tb.sv]
/* Self-checking bench of the flash host against the behavioural flash.
   Assumes the checker binds itself to fag_host. */
`timescale 1ns/1ps
module fag_host_tb import fag_pkg::*; ();
    localparam logic [15:0] MAKER_ID = 16'h005a; // Arbitrary value.
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rv;
    logic [25:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in;
    logic flash_dq_oe, flash_ce_b, flash_oe_b, flash_we_b, flash_reset_b, id_mode, guard_lock;
    int n_fail = 0;
    int check_count = 0;
    fag_host u_fag_host (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in),
        .flash_ce_b(flash_ce_b), .flash_oe_b(flash_oe_b), .flash_we_b(flash_we_b), .flash_reset_b(flash_reset_b));
    fag_flash_model #(.MAKER_ID(MAKER_ID)) u_fag_flash_model (.addr(flash_addr), .dq_out(flash_dq_out),
        .ce_b(flash_ce_b), .oe_b(flash_oe_b), .we_b(flash_we_b), .reset_b(flash_reset_b), .dq_in(flash_dq_in),
        .id_mode(id_mode), .persistent_guard_lock(guard_lock));
    // Clock of 5 ns period.
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // Starts an operation and polls status until it is idle; rv ends as status.
    task automatic op(input logic [2:0] code);
        int i;
        wr(REG_CTRL, {29'h0, code});
        rd(REG_STATUS);
        for (i = 0; i < 1000 && rv[ST_BUSY] !== 1'b0; i++) rd(REG_STATUS);
        if (rv[ST_BUSY] !== 1'b0) n_fail++;
    endtask
    task automatic t_id();
        wr(REG_ADDR, 32'h0);
        op(OP_ID_ENTER);
        chk(rv & 32'h7, 32'h2);
        chk({31'h0, id_mode}, 32'h1);
        repeat (2) begin
            op(OP_READ);
            rd(REG_RDATA);
            chk(rv, {16'h0, MAKER_ID});
        end
        // A sector read in query mode shows its guard state; all start unprotected.
        wr(REG_ADDR, 32'h2);
        op(OP_READ);
        rd(REG_RDATA);
        chk(rv, 32'h0);
        op(OP_WRITE);
        chk(rv & 32'h7, 32'h6);
        op(OP_RESET);
        chk(rv & 32'h7, 32'h0);
        chk({31'h0, id_mode}, 32'h0);
        $display("t_id done");
    endtask
    task automatic t_poll();
        logic [31:0] exp [4] = '{32'h1, 32'h3, 32'h4, 32'h1};
        int i;
        for (i = 0; i < 4; i++) begin
            wr(REG_ADDR, 32'(i));
            op(OP_POLL);
            chk((rv >> ST_POLL_OK) & 32'h7, exp[i]);
        end
        $display("t_poll done");
    endtask
    task automatic t_pw();
        wr(REG_PW0, 32'h1234);
        op(OP_PW_UNLOCK);
        chk({31'h0, guard_lock}, 32'h0);
        repeat (10) @(posedge clk);
        wr(REG_PW0, 32'hffff);
        op(OP_PW_UNLOCK);
        chk({31'h0, guard_lock}, 32'h1);
        op(OP_RESET);
        chk({31'h0, guard_lock}, 32'h0);
        $display("t_pw done");
    endtask
    task automatic t_hw();
        op(OP_ID_ENTER);
        op(OP_HW_RESET);
        chk(rv & 32'h3, 32'h0);
        chk({30'h0, id_mode, guard_lock}, 32'h0);
        rd(REG_CTRL);
        chk(rv & 32'h7, 32'h7);
        rd(8'hfc);
        chk(rv, 32'h0);
        $display("t_hw done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Main sequence after 16 cycles of reset.
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_id();
        t_poll();
        t_pw();
        t_hw();
        test_done();
    end
    // Watchdog against a hung operation.
    initial begin
        #200000;
        n_fail++;
        test_done();
    end
endmodule // fag_host_tb
